// ---- bench/core_model.sv ----
// Behavioural model of the observed microcontroller core
`timescale 1ns/1ps
module core_model (
  // Clock and back-pressure
  input  wire        mclk,
  input  wire        trace_stall_ff,
  // Execution and data writes
  output reg         core_exec,
  output reg  [12:0] core_pc,
  output reg         core_halt,
  output reg         core_cycle,
  output reg         dm_wr,
  output reg  [10:0] dm_wr_addr,
  output reg  [7:0]  dm_wr_data,
  output reg         dm_wr_wide,
  // Core state, sliced onto the block by the bench
  output reg  [63:0] st
);
  // Quiet core at time zero
  initial begin
    core_exec = 1'b0;
    core_pc = 13'h0000;
    core_halt = 1'b0;
    core_cycle = 1'b0;
    dm_wr = 1'b0;
    dm_wr_addr = 11'h000;
    dm_wr_data = 8'h00;
    dm_wr_wide = 1'b0;
    st = 64'h0;
  end

  // One instruction; a stalled core waits, as the real one must
  task exec_one(input [12:0] pc, input [63:0] s);
    integer n;
    begin
      n = 0;
      @(negedge mclk);
      while (trace_stall_ff !== 1'b0 && n < 9000) begin
        n = n + 1;
        @(negedge mclk);
      end
      @(posedge mclk);
      core_exec  <= 1'b1;
      core_cycle <= 1'b1;
      core_pc    <= pc;
      st         <= s;
      @(posedge mclk);
      core_exec  <= 1'b0;
      core_cycle <= 1'b0;
    end
  endtask

  // Halted machine cycles still pulse the cycle line
  task halt_cycles(input integer n);
    begin
      @(posedge mclk);
      core_halt  <= 1'b1;
      core_cycle <= 1'b1;
      repeat (n) @(posedge mclk);
      core_halt  <= 1'b0;
      core_cycle <= 1'b0;
    end
  endtask

  // Data write; bus shows inverted data once released
  task dm_write(input [10:0] a, input [7:0] d, input w);
    begin
      @(posedge mclk);
      dm_wr      <= 1'b1;
      dm_wr_addr <= a;
      dm_wr_data <= d;
      dm_wr_wide <= w;
      @(posedge mclk);
      dm_wr      <= 1'b0;
      dm_wr_data <= ~d;
    end
  endtask
endmodule // core_model

// ---- bench/emulator_trace_coverage_checker.sv ----
// Port-level assertions for the emulator trace and coverage block
`timescale 1ns/1ps
module emulator_trace_coverage_checker (
  // Clock and reset
  input wire        mclk,
  input wire        reset,
  // Host port
  input wire [3:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_ff,
  // Status
  input wire        run_ff,
  input wire        trace_stall_ff
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  reg [13:0] stall_cnt_ff;
  reg [1:0]  grp_ff;
  reg        dm_set_ff;

  // Stall run length, last group written, data address touched
  always @(posedge mclk) begin
    if (reset) begin
      stall_cnt_ff <= 14'h0000;
      grp_ff       <= 2'h0;
      dm_set_ff    <= 1'b0;
    end else begin
      stall_cnt_ff <= trace_stall_ff ? stall_cnt_ff + 14'h0001 : 14'h0000;
      if (reg_wr && reg_addr == 4'h7) grp_ff <= reg_wdata[1:0];
      if (reg_wr && reg_addr == 4'h5) dm_set_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Reset must quiet every output; kept alive through reset on purpose
  a_reset_quiet: assert property (disable iff (1'b0) reset |=>
    !run_ff && !trace_stall_ff && reg_rdata_ff == 32'h0) else $error("outputs not cleared");
  a_rdata_cause: assert property (reg_rdata_ff != 32'h0 |->
    $past(reg_rd)) else $error("read data without a read");
  a_run_start: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[0] |=> run_ff)
    else $error("run did not start");
  a_run_stop: assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[0] |=> !run_ff)
    else $error("run did not stop");
  a_clear_begins: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[1:0] == 2'h3
    && !run_ff |=> trace_stall_ff[*8]) else $error("bitmap clear did not stall core");
  a_clear_bounded: assert property (stall_cnt_ff < 14'h2080)
    else $error("stall held too long");
  a_stopped_only: assert property (reg_rd && run_ff && (reg_addr == 4'h4 || reg_addr == 4'hB)
    |=> reg_rdata_ff == 32'h0) else $error("capture readable while running");
  a_trace_hidden: assert property (reg_rd && run_ff && reg_addr[3:1] == 3'h4
    |=> reg_rdata_ff == 32'h0) else $error("trace readable while running");
  a_dm_default: assert property (reg_rd && reg_addr == 4'h5 && !dm_set_ff
    |=> reg_rdata_ff == 32'h7FF) else $error("data trace address reset value");
  a_group_index: assert property ((reg_wr && reg_addr == 4'h7 && reg_wdata[1:0] != grp_ff
    && !run_ff) ##2 (reg_rd && reg_addr == 4'h6) |=> reg_rdata_ff == 32'h0)
    else $error("group change kept index");

  // Main scenarios reached
  c_clear: cover property (trace_stall_ff ##1 !trace_stall_ff);
  c_group: cover property (reg_wr && reg_addr == 4'h7);
  c_hidden: cover property (reg_rd && run_ff && reg_addr == 4'h4);
endmodule // emulator_trace_coverage_checker

bind emulator_trace_coverage emulator_trace_coverage_checker u_emulator_trace_coverage_checker (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .run_ff(run_ff), .trace_stall_ff(trace_stall_ff));

// ---- bench/test_emulator_trace_coverage.sv ----
// Self-checking bench for the emulator trace and coverage block
`timescale 1ns/1ps
module test_emulator_trace_coverage;
  reg         mclk = 1'b0;
  reg         reset = 1'b1;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  wire [31:0] reg_rdata_ff;
  wire        core_exec, core_halt, core_cycle, dm_wr, dm_wr_wide, run_ff, trace_stall_ff;
  wire [12:0] core_pc;
  wire [10:0] dm_wr_addr;
  wire [7:0]  dm_wr_data;
  wire [63:0] st;
  integer     num_errors = 0;
  integer     num_checks = 0;
  integer     cycles = 0;
  integer     i, m;
  reg  [12:0] p, q;
  reg  [31:0] rd, c0;
  reg  [63:0] rec, s;
  reg  [63:0] exp_q [0:8191];

  emulator_trace_coverage u_emulator_trace_coverage (.*,
    .core_ba(st[63:56]), .core_hl(st[55:48]), .core_carry(st[40]), .core_sp(st[39:32]),
    .port_two(st[23:20]), .port_three(st[19:16]), .port_four(st[15:12]), .port_zero(st[11:8]),
    .port_one(st[7:4]), .bank_common_flag(st[3]), .bank_enable_flag(st[2]),
    .bank_select_zero(st[31:28]), .bank_select_one(st[27:24]));
  core_model u_core_model (.*);

  // Clock, and a cycle ceiling well above the longest path
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end

  // ----------------------------------------
  // Bus tasks, checks, expectations
  // ----------------------------------------
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr    <= 1'b0;
    end
  endtask
  // Every register, trace words too, answers in the cycle after the strobe
  task rd_reg(input [3:0] a, input integer lat);
    begin
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      repeat (lat - 1) @(posedge mclk);
      #1 rd = reg_rdata_ff;
    end
  endtask
  task chk_word(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Whole record, selected group bits included
  task chk_rec(input [63:0] got, input [63:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rd_bit(input [12:0] a, input b);
    begin
      wr(4'hA, {19'h0, a});
      rd_reg(4'hB, 1);
      chk_word(rd, {31'h0, b});
    end
  endtask
  task rd_rec(input [12:0] k);
    begin
      wr(4'h8, {19'h0, k});
      rd_reg(4'h8, 1);
      rec[31:0] = rd;
      rd_reg(4'h9, 1);
      rec[63:32] = rd;
    end
  endtask
  function [12:0] code_top(input [1:0] md);
    code_top = (md == 2'h0) ? 13'h07DF : (md == 2'h1) ? 13'h0FDF : 13'h1FDF;
  endfunction
  function [10:0] data_base(input [1:0] md);
    data_base = (md == 2'h0) ? 11'h780 : (md == 2'h1) ? 11'h700 : 11'h600;
  endfunction
  function [63:0] rec_exp(input [63:0] v, input [7:0] d, input [1:0] g);
    rec_exp = (v & 64'hFFFF01FF00FF0000) | {32'h0, d, 24'h0} |
              ((g == 2'h0) ? {54'h0, v[3:2], v[31:24]} :
                             {56'h0, v[15:12], ((g == 2'h1) ? v[11:8] : v[7:4])});
  endfunction
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hC5037E8A));
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(4'h5, 1);
    chk_word(rd, 32'h7FF);
    rd_reg(4'h6, 1);
    chk_word(rd, 32'h0);
    $display("reset values done");
    // Per mode: data address floor, then bitmap bounds and clearing
    for (m = 0; m < 3; m = m + 1) begin
      wr(4'h0, {28'h0, m[1:0], 2'h0});
      wr(4'h5, {21'h0, data_base(m[1:0]) - 11'h001});
      rd_reg(4'h5, 1);
      chk_word(rd, (m == 0) ? 32'h7FF : {21'h0, data_base(m[1:0] - 2'h1)});
      wr(4'h5, {21'h0, data_base(m[1:0])});
      rd_reg(4'h5, 1);
      chk_word(rd, {21'h0, data_base(m[1:0])});
      wr(4'h0, {28'h0, m[1:0], 2'h3});
      s = {$urandom, $urandom};
      p = s[12:0] % code_top(m[1:0]);
      u_core_model.exec_one(code_top(m[1:0]), s);
      u_core_model.exec_one(code_top(m[1:0]) + 13'h0001, s);
      u_core_model.exec_one(p, s);
      wr(4'h0, {28'h0, m[1:0], 2'h0});
      rd_bit(code_top(m[1:0]), 1'b1);
      rd_bit(code_top(m[1:0]) + 13'h0001, 1'b0);
      rd_bit(p, 1'b1);
      if (m > 0 && q != p) rd_bit(q, 1'b0);
      q = p;
    end
    $display("mode and bitmap done");
    // Counting window, second pass with halted cycles inside it
    wr(4'h2, 32'h12);
    wr(4'h3, 32'h18);
    for (m = 0; m < 2; m = m + 1) begin
      wr(4'h0, 32'hB);
      for (i = 16; i < 32; i = i + 1) begin
        u_core_model.exec_one(i[12:0], s);
        if (m == 1 && i == 20) u_core_model.halt_cycles(5);
      end
      rd_reg(4'h4, 1);
      chk_word(rd, 32'h0);
      rd_reg(4'h8, 1);
      chk_word(rd, 32'h0);
      wr(4'h0, 32'h8);
      rd_reg(4'h4, 1);
      if (m == 0) c0 = rd;
      else chk_word(rd, c0);
    end
    chk_word({31'h0, c0 >= 32'h5 && c0 <= 32'h7}, 32'h1);
    $display("cycle counter done");
    // Records with the traced data byte, narrow and wide writes
    wr(4'h7, 32'h1);
    rd_reg(4'h6, 1);
    chk_word(rd, 32'h0);
    wr(4'h5, 32'h7F0);
    wr(4'h0, 32'h9);
    u_core_model.dm_write(11'h7F0, 8'hA5, 1'b0);
    u_core_model.dm_write(11'h7EF, 8'h12, 1'b1);
    for (i = 0; i < 4; i = i + 1) begin
      if (i == 2) u_core_model.dm_write(11'h7F0, 8'h3C, 1'b1);
      s = {$urandom, $urandom};
      exp_q[i] = rec_exp(s, (i < 2) ? 8'hF5 : 8'h3C, 2'h1);
      u_core_model.exec_one(i[12:0], s);
    end
    wr(4'h0, 32'h8);
    rd_reg(4'h6, 1);
    chk_word(rd, 32'h4);
    for (i = 0; i < 4; i = i + 1) begin
      rd_rec(i[12:0]);
      chk_rec(rec, exp_q[i]);
    end
    $display("records done");
    // Fill past the end of the ring and look at both ends
    wr(4'h7, 32'h2);
    rd_reg(4'h1, 1);
    chk_word(rd & 32'h1, 32'h0);
    wr(4'h0, 32'h9);
    for (i = 0; i < 8195; i = i + 1) begin
      s = {$urandom, $urandom};
      exp_q[i % 8192] = rec_exp(s, 8'h3C, 2'h2);
      u_core_model.exec_one(i[12:0], s);
    end
    wr(4'h0, 32'h8);
    rd_reg(4'h6, 1);
    chk_word(rd, 32'h3);
    rd_reg(4'h1, 1);
    chk_word(rd & 32'h1, 32'h1);
    rd_rec(13'h0000);
    chk_rec(rec, exp_q[0]);
    rd_rec(13'h1FFF);
    chk_rec(rec, exp_q[8191]);
    $display("ring wrap done");
    complete_run;
  end
endmodule // test_emulator_trace_coverage

// ---- core/emu_trace_map.vh ----
// Constants for the emulator trace and coverage block
`ifndef EMU_TRACE_MAP_VH
`define EMU_TRACE_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_CC_START    4'h2
`define REG_CC_STOP     4'h3
`define REG_CC_COUNT    4'h4
`define REG_DM_ADDR     4'h5
`define REG_TR_INDEX    4'h6
`define REG_TR_SEL      4'h7
`define REG_TR_LO       4'h8
`define REG_TR_HI       4'h9
`define REG_BM_ADDR     4'hA
`define REG_BM_DATA     4'hB

// ----------------------------------------------------------------
// Fields and limits
// ----------------------------------------------------------------
`define CTRL_RUN        0
`define CTRL_GO_CLEAR   1
`define MODE_LO         2
`define MODE_HI         3
`define MODE_SMALL      2'h0
`define MODE_MEDIUM     2'h1
`define MODE_LARGE      2'h2
`define CODE_TOP_SMALL  13'h07DF
`define CODE_TOP_MEDIUM 13'h0FDF
`define CODE_TOP_LARGE  13'h1FDF
`define DATA_LO_SMALL   11'h780
`define DATA_LO_MEDIUM  11'h700
`define DATA_LO_LARGE   11'h600
`define DATA_TOP        11'h7FF
`define GRP_BANK        2'h0
`define GRP_P4_P0       2'h1
`define GRP_P4_P1       2'h2
`define TR_DEPTH        8192
`define TR_AW           13
`define TR_W            64
`define TR_LAST         13'h1FFF
`define BM_WORDS        8192
`define UPPER_ONES      4'hF
`define FIFO_DEPTH      32
`define FIFO_AW         5

`endif

// ---- core/emulator_trace_coverage.v ----
// Coverage bitmap, cycle counter and ring trace for the emulator
`timescale 1ns/1ps
`include "emu_trace_map.vh"
module emulator_trace_coverage (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset,
  // Host register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_ff,
  // Observed core: instruction execution
  input  wire        core_exec,
  input  wire [12:0] core_pc,
  input  wire        core_halt,
  input  wire        core_cycle,
  // Observed core: data memory writes
  input  wire        dm_wr,
  input  wire [10:0] dm_wr_addr,
  input  wire [7:0]  dm_wr_data,
  input  wire        dm_wr_wide,
  // Observed core: state captured per record
  input  wire [7:0]  core_ba,
  input  wire [7:0]  core_hl,
  input  wire        core_carry,
  input  wire [7:0]  core_sp,
  input  wire [3:0]  port_two,
  input  wire [3:0]  port_three,
  input  wire [3:0]  port_four,
  input  wire [3:0]  port_zero,
  input  wire [3:0]  port_one,
  input  wire        bank_common_flag,
  input  wire        bank_enable_flag,
  input  wire [3:0]  bank_select_zero,
  input  wire [3:0]  bank_select_one,
  // Status towards the emulator
  output reg         run_ff,
  output reg         trace_stall_ff
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg  [1:0]  mode_ff;
  reg  [12:0] cc_start_ff;
  reg  [12:0] cc_stop_ff;
  reg  [31:0] cc_count_ff;
  reg         cc_active_ff;
  reg  [10:0] dm_addr_ff;
  reg  [7:0]  dm_value_ff;
  reg  [1:0]  grp_sel_ff;
  reg  [12:0] trace_write_index_ff;
  reg         wrapped_ff;
  reg  [12:0] host_tr_idx_ff;
  reg  [12:0] bm_addr_ff;
  reg  [12:0] clr_idx_ff;
  reg         clearing_ff;
  wire [12:0] tr_rd_idx;
  wire        start_clear;
  reg  [`BM_WORDS-1:0] bitmap_ff;
  reg  [31:0] nxt_rdata;
  reg  [15:0] grp_field;
  wire [63:0] record;
  wire        rec_ready;
  wire        st_valid;
  wire [63:0] st_data;
  wire [63:0] tr_rdata;
  wire        st_take;
  wire        pc_ok;
  wire        wr_ctrl;

  // Code space top per chip mode
  function [12:0] code_top;
    input [1:0] m;
    begin
      case (m)
        `MODE_SMALL:  code_top = `CODE_TOP_SMALL;
        `MODE_MEDIUM: code_top = `CODE_TOP_MEDIUM;
        default:      code_top = `CODE_TOP_LARGE;
      endcase
    end
  endfunction

  // Data space base per chip mode
  function [10:0] data_lo;
    input [1:0] m;
    begin
      case (m)
        `MODE_SMALL:  data_lo = `DATA_LO_SMALL;
        `MODE_MEDIUM: data_lo = `DATA_LO_MEDIUM;
        default:      data_lo = `DATA_LO_LARGE;
      endcase
    end
  endfunction

  assign pc_ok   = (core_pc <= code_top(mode_ff));
  assign wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
  assign start_clear = wr_ctrl && reg_wdata[`CTRL_GO_CLEAR] && !run_ff;

  // ------------------------------------------------------------
  // Control, setup registers
  // ------------------------------------------------------------
  // Only the mode change is refused while running; the data address refuses values below the mode's data base, the rest take host writes at any time
  always @(posedge mclk) begin
    if (reset) begin
      run_ff      <= 1'b0;
      mode_ff     <= `MODE_LARGE;
      cc_start_ff <= 13'h0000;
      cc_stop_ff  <= 13'h0000;
      dm_addr_ff  <= `DATA_TOP;
      grp_sel_ff  <= `GRP_BANK;
      host_tr_idx_ff <= 13'h0000;
      bm_addr_ff  <= 13'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: begin
          run_ff <= reg_wdata[`CTRL_RUN];
          if (!run_ff)
            mode_ff <= reg_wdata[`MODE_HI:`MODE_LO];
        end
        `REG_CC_START: cc_start_ff <= reg_wdata[12:0];
        `REG_CC_STOP:  cc_stop_ff  <= reg_wdata[12:0];
        `REG_DM_ADDR:  if (reg_wdata[10:0] >= data_lo(mode_ff))
                         dm_addr_ff <= reg_wdata[10:0];
        `REG_TR_SEL:   grp_sel_ff <= reg_wdata[1:0];
        `REG_TR_LO:    host_tr_idx_ff <= reg_wdata[12:0];
        `REG_BM_ADDR:  bm_addr_ff <= reg_wdata[12:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Coverage bitmap with sweep clear
  // ------------------------------------------------------------
  // Clear walks one bit per cycle; the core is held off by trace_stall
  always @(posedge mclk) begin
    if (reset) begin
      clearing_ff <= 1'b0;
      clr_idx_ff  <= 13'h0000;
    end else if (wr_ctrl && reg_wdata[`CTRL_GO_CLEAR] && !run_ff) begin
      clearing_ff <= 1'b1;
      clr_idx_ff  <= 13'h0000;
    end else if (clearing_ff) begin
      clr_idx_ff  <= clr_idx_ff + 13'h0001;
      if (clr_idx_ff == `CODE_TOP_LARGE)
        clearing_ff <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `BM_WORDS; gi = gi + 1) begin : g_bm
      always @(posedge mclk) begin
        if (reset)
          bitmap_ff[gi] <= 1'b0;
        else if (clearing_ff && clr_idx_ff == gi)
          bitmap_ff[gi] <= 1'b0;
        else if (run_ff && core_exec && pc_ok && core_pc == gi)
          bitmap_ff[gi] <= 1'b1;
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Cycle counter
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      cc_active_ff <= 1'b0;
      cc_count_ff  <= 32'h00000000;
    end else begin
      if (wr_ctrl && reg_wdata[`CTRL_GO_CLEAR] && !run_ff)
        cc_count_ff <= 32'h00000000;
      else if (run_ff && cc_active_ff && core_cycle && !core_halt)
        cc_count_ff <= cc_count_ff + 32'h00000001;
      if (run_ff && core_exec && core_pc == cc_start_ff)
        cc_active_ff <= 1'b1;
      else if (run_ff && core_exec && core_pc == cc_stop_ff)
        cc_active_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Data memory write capture
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    if (reset)
      dm_value_ff <= 8'hFF;
    else if (dm_wr && dm_wr_addr == dm_addr_ff)
      dm_value_ff <= dm_wr_wide ? dm_wr_data
                                : {`UPPER_ONES, dm_wr_data[3:0]};
  end

  // ------------------------------------------------------------
  // Record assembly and FIFO
  // ------------------------------------------------------------
  always @* begin
    case (grp_sel_ff)
      `GRP_P4_P0: grp_field = {8'h00, port_four, port_zero};
      `GRP_P4_P1: grp_field = {8'h00, port_four, port_one};
      default:    grp_field = {6'h00, bank_common_flag, bank_enable_flag,
                               bank_select_zero, bank_select_one};
    endcase
  end

  assign record = {core_ba, core_hl, 7'h00, core_carry, core_sp,
                   dm_value_ff, port_two, port_three, grp_field};

  trace_fifo #(
    .WIDTH (`TR_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (run_ff && core_exec && !clearing_ff),
    .in_ready  (rec_ready),
    .in_data   (record),
    .out_valid (st_valid),
    .out_ready (1'b1),
    .out_data  (st_data)
  );

  // Full FIFO stalls the core rather than dropping records; a clear stalls at once
  always @(posedge mclk) begin
    if (reset)
      trace_stall_ff <= 1'b0;
    else
      trace_stall_ff <= !rec_ready || clearing_ff || start_clear;
  end

  assign st_take = st_valid;

  // Read index follows a host write at once, so a trace read may follow it
  assign tr_rd_idx = (reg_wr && reg_addr == `REG_TR_LO) ? reg_wdata[12:0] : host_tr_idx_ff;

  // ------------------------------------------------------------
  // Trace write index and wrap flag
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      trace_write_index_ff <= 13'h0000;
      wrapped_ff           <= 1'b0;
    end else if (reg_wr && reg_addr == `REG_TR_SEL &&
                 reg_wdata[1:0] != grp_sel_ff) begin
      trace_write_index_ff <= 13'h0000;
      wrapped_ff           <= 1'b0;
    end else if (st_take) begin
      trace_write_index_ff <= trace_write_index_ff + 13'h0001;
      if (trace_write_index_ff == `TR_LAST)
        wrapped_ff <= 1'b1;
    end
  end

  trace_ram #(
    .WIDTH (`TR_W),
    .DEPTH (`TR_DEPTH),
    .AW    (`TR_AW)
  ) u_ram (
    .mclk    (mclk),
    .wr_en   (st_take),
    .wr_addr (trace_write_index_ff),
    .wr_data (st_data),
    .rd_addr (tr_rd_idx),
    .rd_data (tr_rdata)
  );

  // ------------------------------------------------------------
  // Read path, one cycle latency
  // ------------------------------------------------------------
  // Captured data read as zero while running
  always @* begin
    nxt_rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:     nxt_rdata = {28'h0000000, mode_ff, 1'b0, run_ff};
        `REG_STATUS:   nxt_rdata = {29'h00000000, trace_stall_ff, clearing_ff,
                                    wrapped_ff};
        `REG_CC_START: nxt_rdata = {19'h00000, cc_start_ff};
        `REG_CC_STOP:  nxt_rdata = {19'h00000, cc_stop_ff};
        `REG_CC_COUNT: nxt_rdata = run_ff ? 32'h00000000 : cc_count_ff;
        `REG_DM_ADDR:  nxt_rdata = {21'h000000, dm_addr_ff};
        `REG_TR_INDEX: nxt_rdata = {19'h00000, trace_write_index_ff};
        `REG_TR_SEL:   nxt_rdata = {30'h00000000, grp_sel_ff};
        `REG_TR_LO:    nxt_rdata = run_ff ? 32'h00000000 : tr_rdata[31:0];
        `REG_TR_HI:    nxt_rdata = run_ff ? 32'h00000000 : tr_rdata[63:32];
        `REG_BM_ADDR:  nxt_rdata = {19'h00000, bm_addr_ff};
        `REG_BM_DATA:  nxt_rdata = (run_ff || bm_addr_ff > code_top(mode_ff)) ?
                                   32'h00000000 :
                                   {31'h00000000, bitmap_ff[bm_addr_ff]};
        default:       nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // Read data stand for one cycle only, then fall back to zero
  always @(posedge mclk) begin
    if (reset)
      reg_rdata_ff <= 32'h00000000;
    else
      reg_rdata_ff <= nxt_rdata;
  end
endmodule // emulator_trace_coverage

// ---- core/trace_fifo.v ----
// Record FIFO between capture and trace store
`timescale 1ns/1ps
module trace_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_ff;
  reg [AW:0]      rd_ptr_ff;
  wire            full;
  wire            empty;

  // ------------------------------------------------------------
  // Flags: extra pointer bit separates full from empty
  // ------------------------------------------------------------
  assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                     (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty     = (wr_ptr_ff == rd_ptr_ff);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  // Pointer update
  always @(posedge mclk) begin
    if (reset) begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        mem[wr_ptr_ff[AW-1:0]] <= in_data;
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (out_ready && !empty)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule // trace_fifo

// ---- core/trace_ram.v ----
// Single-port-write, registered-read memory
`timescale 1ns/1ps
module trace_ram #(
  parameter WIDTH = 64,
  parameter DEPTH = 8192,
  parameter AW    = 13
) (
  // Clock
  input  wire             mclk,
  // Write port
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  // Read port
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Write and registered read
  always @(posedge mclk) begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end
endmodule // trace_ram
